// ---- include/pldc_map.svh ----
// pldc_map.svh: offsets, sizes and counts of the configurable logic cell
// assumes: included by the package and by any file that needs raw numbers
`ifndef PLDC_MAP_SVH
`define PLDC_MAP_SVH

// working register indices on the register port
`define PLDC_REG_ACC0    3'h0
`define PLDC_REG_ACC1    3'h1
`define PLDC_REG_OPND0   3'h2
`define PLDC_REG_OPND1   3'h3
`define PLDC_REG_QUEUE0  3'h4
`define PLDC_REG_QUEUE1  3'h5

// datapath sizes
`define PLDC_DATA_W      8
`define PLDC_MSB_W       3
`define PLDC_CFG_WORDS   8
`define PLDC_CFG_AW      3
`define PLDC_CFG_W       16
`define PLDC_ROUTE_OUTS  6
`define PLDC_COND_W      16
`define PLDC_COND_SEL_W  4

// logic array sizes
`define PLDC_PLA_IN      12
`define PLDC_PLA_TERMS   8
`define PLDC_PLA_OUT     4

// queue sizes
`define PLDC_Q_DEPTH     4
`define PLDC_Q_AW        2
`define PLDC_Q_CW        3

// reset value of every working register
`define PLDC_REG_RESET   8'h00

`endif

// ---- include/pldc_pkg.sv ----
// pldc_pkg: types shared by the configurable logic cell and its leaves
// assumes: pldc_map.svh is reachable on the include path
`include "pldc_map.svh"

package pldc_pkg;

   // alu operations
   typedef enum logic [2:0] {
      pldc_op_inc, pldc_op_dec, pldc_op_add, pldc_op_sub,
      pldc_op_and, pldc_op_or, pldc_op_xor, pldc_op_pass
   } pldc_op_type;

   // post-alu shift stage
   typedef enum logic [1:0] {
      pldc_sh_none, pldc_sh_left, pldc_sh_right, pldc_sh_swap
   } pldc_shift_type;

   // one word of the per-cycle configuration ram, 16 bits
   typedef struct packed {
      logic           q1_go;    // advance queue one
      logic           q0_go;    // advance queue zero
      logic           crc_en;   // crc / sequence step instead of alu
      logic           mask_en;  // apply or mask
      logic           cin_en;   // take carry from neighbour
      logic [1:0]     dest;     // bit0 acc zero, bit1 acc one
      pldc_shift_type shift;
      logic [1:0]     src_b;    // 0 acc0, 1 acc1, 2 opnd0, 3 opnd1
      logic [1:0]     src_a;
      pldc_op_type    op;
   } pldc_cfg_word_type;

   // static datapath setup
   typedef struct packed {
      logic [`PLDC_MSB_W-1:0]  msb;
      logic [7:0]              or_mask;
      logic [7:0]              cmp_mask0;
      logic [7:0]              cmp_mask1;
      logic [1:0]              cmp_sel0;
      logic [1:0]              cmp_sel1;
      logic [7:0]              poly;
      logic [1:0]              q_out;     // per queue: 1 output buffer
      logic                    q_cap_alu; // output queues capture alu
      logic                    q_ld_acc;  // input queues load accumulators
      logic                    chain_eq;  // fold neighbour equality in
      logic [`PLDC_ROUTE_OUTS-1:0][`PLDC_COND_SEL_W-1:0] out_sel;
   } pldc_ctrl_type;

   // logic array setup
   typedef struct packed {
      logic [`PLDC_PLA_TERMS-1:0][`PLDC_PLA_IN-1:0]  use_t;
      logic [`PLDC_PLA_TERMS-1:0][`PLDC_PLA_IN-1:0]  use_c;
      logic [`PLDC_PLA_OUT-1:0][`PLDC_PLA_TERMS-1:0] or_sel;
      logic [`PLDC_PLA_OUT-1:0]                      reg_out;
   } pldc_pla_cfg_type;

   // register port request
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        rd;
      logic [2:0]  addr;
      logic [7:0]  wdata;
   } pldc_bus_req_type;

   // state of one logic array
   typedef struct packed {
      logic [`PLDC_PLA_OUT-1:0] out;
   } pldc_pla_state_type;

   // state of one queue
   typedef struct packed {
      logic [`PLDC_Q_DEPTH-1:0][7:0] mem;
      logic [`PLDC_Q_AW-1:0]         wp;
      logic [`PLDC_Q_AW-1:0]         rp;
      logic [`PLDC_Q_CW-1:0]         cnt;
      logic [7:0]                    head;
   } pldc_queue_state_type;

   // state of the cell
   typedef struct packed {
      logic [7:0]                     acc0;
      logic [7:0]                     acc1;
      logic [7:0]                     opnd0;
      logic [7:0]                     opnd1;
      logic [7:0]                     rdata;
      logic [`PLDC_ROUTE_OUTS-1:0]    route;
   } pldc_cell_state_type;

endpackage

// ---- rtl/pldc_logic_array.sv ----
// pldc_logic_array: product-term array, 12 inputs, 8 terms, 4 outputs
// assumes: inputs come from routing on the same clock, setup held static
`timescale 1ns/10ps
module pldc_logic_array #(
   parameter int NIN  = `PLDC_PLA_IN,
   parameter int NPT  = `PLDC_PLA_TERMS,
   parameter int NOUT = `PLDC_PLA_OUT
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      nrst,
   // setup and routed inputs
   input  wire pldc_pkg::pldc_pla_cfg_type cfg,
   input  wire logic [NIN-1:0]            pin,
   // outputs to routing
   output logic [NOUT-1:0]                pout
);
   import pldc_pkg::*;

   pldc_pla_state_type st_q;
   pldc_pla_state_type st_d;
   logic [NPT-1:0]     term;
   logic [NOUT-1:0]    sum;

   // terms and sums; a term with no input stays low
   always_comb begin
      for (int p = 0; p < NPT; p++) begin
         term[p] = |(cfg.use_t[p] | cfg.use_c[p]) &
                   &((pin | ~cfg.use_t[p]) & (~pin | ~cfg.use_c[p]));
      end
      for (int o = 0; o < NOUT; o++) begin
         sum[o] = |(term & cfg.or_sel[o]);
      end
      st_d     = st_q;
      st_d.out = sum;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pout = (cfg.reg_out & st_q.out) | (~cfg.reg_out & sum);
endmodule

// ---- rtl/pldc_queue.sv ----
// pldc_queue: four-byte queue, head held in a register
// assumes: one-cycle push and pop strobes on clk
`timescale 1ns/10ps
module pldc_queue (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // filling side
   input  wire logic       push,
   input  wire logic [7:0] din,
   // draining side
   input  wire logic       pop,
   output logic [7:0]      head,
   // status
   output logic            empty,
   output logic            full
);
   import pldc_pkg::*;

   pldc_queue_state_type st_q;
   pldc_queue_state_type st_d;
   logic                 do_push;
   logic                 do_pop;

   assign empty   = (st_q.cnt == 3'h0);
   assign full    = (st_q.cnt == 3'(`PLDC_Q_DEPTH));
   assign do_pop  = pop & ~empty;
   assign do_push = push & (~full | do_pop);

   // head taken from next state so back-to-back pops see fresh data
   always_comb begin
      st_d = st_q;
      if (do_push) begin
         st_d.mem[st_q.wp] = din;
         st_d.wp           = st_q.wp + 2'h1;
      end
      if (do_pop) begin
         st_d.rp = st_q.rp + 2'h1;
      end
      st_d.cnt  = st_q.cnt + 3'(do_push) - 3'(do_pop);
      st_d.head = st_d.mem[st_d.rp];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign head = st_q.head;
endmodule

// ---- rtl/pldc_cell.sv ----
// pldc_cell: logic cell, two arrays plus 8-bit datapath
// assumes: all inputs on clk; setup held static
// Behaviour
// - each logic array takes 12 routed inputs, any usable by every term
// - a product term ands one to twelve inputs, true or inverted each
// - each array output ors one to eight terms, same width for all
// - each array output is selectable combinational or registered
// - the cell holds two independent logic arrays and one datapath
// - single-cycle 8-bit alu with compare and condition logic
// - six working registers readable by cpu or dma, writable except a queue set as output buffer
// - accumulators feed the alu, take its result, and feed compares
// - operand registers feed alu and compares, never take results
// - two four-byte queues load registers or capture accumulators or alu
// - each queue set alone as input or output buffer
// - queue status is selectable onto the routing outputs
// - eight 16-bit configuration words, picked each cycle by routed address
// - alu does increment, decrement, add, subtract, and, or, xor, pass
// - after the alu: shift left, shift right, nibble swap, or mask
// - two masked comparators over selectable register pairs
// - zero, all-ones, overflow detected; chosen conditions drive routing
// - programmable most significant bit for arithmetic and shifts
// - one crc or sequence step per cycle, programmable polynomial, width
// - carries, shift data and comparator zero equality chain to neighbour cells
`timescale 1ns/10ps
module pldc_cell (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  nrst,
   // register port from the system bus
   input  wire pldc_pkg::pldc_bus_req_type            bus_req,
   output logic [7:0]                                 bus_rdata,
   // static setup
   input  wire pldc_pkg::pldc_pla_cfg_type            pla0_cfg,
   input  wire pldc_pkg::pldc_pla_cfg_type            pla1_cfg,
   input  wire pldc_pkg::pldc_ctrl_type               ctrl,
   input  wire pldc_pkg::pldc_cfg_word_type [`PLDC_CFG_WORDS-1:0] cfg_ram,
   // routing
   input  wire logic [`PLDC_PLA_IN-1:0]               pla0_in,
   input  wire logic [`PLDC_PLA_IN-1:0]               pla1_in,
   output logic [`PLDC_PLA_OUT-1:0]                   pla0_out,
   output logic [`PLDC_PLA_OUT-1:0]                   pla1_out,
   input  wire logic [`PLDC_CFG_AW-1:0]               cfg_addr,
   input  wire logic                                  shift_in,
   output logic [`PLDC_ROUTE_OUTS-1:0]                route_out,
   // chaining to neighbours
   input  wire logic                                  chain_cin,
   input  wire logic                                  chain_sin,
   input  wire logic                                  chain_eq_in,
   output logic                                       chain_cout,
   output logic                                       chain_sout,
   output logic                                       chain_eq_out
);
   import pldc_pkg::*;

   // pick a working register
   function automatic logic [7:0] pick(input logic [1:0] s, input pldc_cell_state_type r);
      case (s)
         2'h0:    pick = r.acc0;
         2'h1:    pick = r.acc1;
         2'h2:    pick = r.opnd0;
         default: pick = r.opnd1;
      endcase
   endfunction

   // compare pairs: acc0/opnd0, acc1/opnd1, acc0/acc1, acc1/opnd0
   function automatic logic [15:0] pair(input logic [1:0] s, input pldc_cell_state_type r);
      case (s)
         2'h0:    pair = {r.acc0, r.opnd0};
         2'h1:    pair = {r.acc1, r.opnd1};
         2'h2:    pair = {r.acc0, r.acc1};
         default: pair = {r.acc1, r.opnd0};
      endcase
   endfunction

   pldc_cell_state_type st_q;
   pldc_cell_state_type st_d;
   pldc_cfg_word_type   w;
   logic [7:0]          msk;
   logic [7:0]          opa;
   logic [7:0]          opb;
   logic [7:0]          addb;
   logic                cin;
   logic [8:0]          sum;
   logic [7:0]          alu;
   logic [7:0]          shf;
   logic [7:0]          res;
   logic                sout;
   logic                cout;
   logic                ovf;
   logic                fb;
   logic [15:0]         p0;
   logic [15:0]         p1;
   logic                eq0;
   logic                lt0;
   logic                eq1;
   logic                lt1;
   logic [`PLDC_COND_W-1:0] cond;
   logic [1:0]          q_push;
   logic [1:0]          q_pop;
   logic [7:0]          q_din [2];
   logic [7:0]          q_head [2];
   logic [1:0]          q_empty;
   logic [1:0]          q_full;
   logic                bus_wr;
   logic                bus_rd;

   pldc_logic_array u_pla0 (
      .clk  (clk),
      .nrst (nrst),
      .cfg  (pla0_cfg),
      .pin  (pla0_in),
      .pout (pla0_out)
   );

   pldc_logic_array u_pla1 (
      .clk  (clk),
      .nrst (nrst),
      .cfg  (pla1_cfg),
      .pin  (pla1_in),
      .pout (pla1_out)
   );

   assign w = cfg_ram[cfg_addr];

   assign msk = 8'hff >> (3'h7 - ctrl.msb);

   // operand select and adder
   always_comb begin
      opa = pick(w.src_a, st_q) & msk;
      opb = pick(w.src_b, st_q) & msk;
      cin = w.cin_en ? chain_cin : 1'b1;
      case (w.op)
         pldc_op_inc: begin
            addb = 8'h00;
         end
         pldc_op_dec: begin
            addb = msk;
            cin  = w.cin_en ? chain_cin : 1'b0;
         end
         pldc_op_add: begin
            addb = opb;
            cin  = w.cin_en & chain_cin;
         end
         pldc_op_sub: begin
            addb = ~opb & msk;
         end
         default: begin
            addb = 8'h00;
            cin  = 1'b0;
         end
      endcase
      sum = {1'b0, opa} + {1'b0, addb} + {8'h00, cin};
   end

   always_comb begin
      case (w.op)
         pldc_op_and:  alu = opa & opb;
         pldc_op_or:   alu = opa | opb;
         pldc_op_xor:  alu = opa ^ opb;
         pldc_op_pass: alu = opa;
         default:      alu = sum[7:0] & msk;
      endcase
   end

   assign cout = (w.op <= pldc_op_sub) ? sum[{1'b0, ctrl.msb} + 4'h1] : 1'b0;
   assign ovf  = (w.op <= pldc_op_sub) &
                 (opa[ctrl.msb] == addb[ctrl.msb]) & (alu[ctrl.msb] != opa[ctrl.msb]);

   // crc feedback; zero data in gives a sequence
   assign fb = opa[ctrl.msb] ^ (shift_in | chain_sin);

   // shift stage, crc step and or mask
   always_comb begin
      sout = 1'b0;
      case (w.shift)
         pldc_sh_left: begin
            shf  = ((alu << 1) | {7'h00, chain_sin}) & msk;
            sout = alu[ctrl.msb];
         end
         pldc_sh_right: begin
            shf  = (alu >> 1) | ({7'h00, chain_sin} << ctrl.msb);
            sout = alu[0];
         end
         pldc_sh_swap: begin
            shf = {alu[3:0], alu[7:4]};
         end
         default: begin
            shf = alu;
         end
      endcase
      if (w.crc_en) begin
         shf  = ((opa << 1) & msk) ^ (fb ? (ctrl.poly & msk) : 8'h00);
         sout = fb;
      end
      res = w.mask_en ? (shf | ctrl.or_mask) : shf;
   end

   assign p0  = pair(ctrl.cmp_sel0, st_q);
   assign p1  = pair(ctrl.cmp_sel1, st_q);
   assign eq0 = (((p0[15:8] ^ p0[7:0]) & ctrl.cmp_mask0) == 8'h00) &
                (~ctrl.chain_eq | chain_eq_in);
   assign lt0 = (p0[15:8] & ctrl.cmp_mask0) < (p0[7:0] & ctrl.cmp_mask0);
   assign eq1 = ((p1[15:8] ^ p1[7:0]) & ctrl.cmp_mask1) == 8'h00;
   assign lt1 = (p1[15:8] & ctrl.cmp_mask1) < (p1[7:0] & ctrl.cmp_mask1);

   assign cond = {q_full[1], q_empty[1], q_full[0], q_empty[0],
                  fb, sout, ovf, cout,
                  (st_q.acc1 & msk) == msk, (st_q.acc0 & msk) == msk,
                  (st_q.acc1 & msk) == 8'h00, (st_q.acc0 & msk) == 8'h00,
                  lt1, eq1, lt0, eq0};

   // chain outputs, combinational so wide sums settle
   assign chain_cout   = cout;
   assign chain_sout   = sout;
   assign chain_eq_out = eq0;

   // bus strobes
   assign bus_wr = bus_req.sel & bus_req.wr;
   assign bus_rd = bus_req.sel & bus_req.rd;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic go;
         logic hit;
         go  = (i == 0) ? w.q0_go : w.q1_go;
         hit = bus_req.addr == (`PLDC_REG_QUEUE0 + 3'(i));
         if (ctrl.q_out[i]) begin
            q_push[i] = go;
            q_pop[i]  = bus_rd & hit;
         end else begin
            q_push[i] = bus_wr & hit;
            q_pop[i]  = go;
         end
         if (!ctrl.q_out[i]) begin
            q_din[i] = bus_req.wdata;
         end else if (ctrl.q_cap_alu) begin
            q_din[i] = res;
         end else begin
            q_din[i] = (i == 0) ? st_q.acc0 : st_q.acc1;
         end
      end
   end

   pldc_queue u_q0 (
      .clk   (clk),
      .nrst  (nrst),
      .push  (q_push[0]),
      .din   (q_din[0]),
      .pop   (q_pop[0]),
      .head  (q_head[0]),
      .empty (q_empty[0]),
      .full  (q_full[0])
   );

   pldc_queue u_q1 (
      .clk   (clk),
      .nrst  (nrst),
      .push  (q_push[1]),
      .din   (q_din[1]),
      .pop   (q_pop[1]),
      .head  (q_head[1]),
      .empty (q_empty[1]),
      .full  (q_full[1])
   );

   // next state: bus write beats queue load beats alu result
   always_comb begin
      logic ld0;
      logic ld1;
      ld0  = ~ctrl.q_out[0] & w.q0_go & ~q_empty[0];
      ld1  = ~ctrl.q_out[1] & w.q1_go & ~q_empty[1];
      st_d = st_q;
      if (w.dest[0]) begin
         st_d.acc0 = res;
      end
      if (w.dest[1]) begin
         st_d.acc1 = res;
      end
      if (ld0 && ctrl.q_ld_acc) begin
         st_d.acc0 = q_head[0];
      end else if (ld0) begin
         st_d.opnd0 = q_head[0];
      end
      if (ld1 && ctrl.q_ld_acc) begin
         st_d.acc1 = q_head[1];
      end else if (ld1) begin
         st_d.opnd1 = q_head[1];
      end
      if (bus_wr) begin
         case (bus_req.addr)
            `PLDC_REG_ACC0:  st_d.acc0  = bus_req.wdata;
            `PLDC_REG_ACC1:  st_d.acc1  = bus_req.wdata;
            `PLDC_REG_OPND0: st_d.opnd0 = bus_req.wdata;
            `PLDC_REG_OPND1: st_d.opnd1 = bus_req.wdata;
            default:         st_d.acc0  = st_d.acc0;
         endcase
      end
      if (bus_rd) begin
         case (bus_req.addr)
            `PLDC_REG_ACC0:   st_d.rdata = st_q.acc0;
            `PLDC_REG_ACC1:   st_d.rdata = st_q.acc1;
            `PLDC_REG_OPND0:  st_d.rdata = st_q.opnd0;
            `PLDC_REG_OPND1:  st_d.rdata = st_q.opnd1;
            `PLDC_REG_QUEUE0: st_d.rdata = q_head[0];
            `PLDC_REG_QUEUE1: st_d.rdata = q_head[1];
            default:          st_d.rdata = 8'h00;
         endcase
      end
      for (int i = 0; i < `PLDC_ROUTE_OUTS; i++) begin
         st_d.route[i] = cond[ctrl.out_sel[i]];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus_rdata = st_q.rdata;
   assign route_out = st_q.route;
endmodule

// ---- bench/pldc_bus_model.sv ----
// pldc_bus_model: cpu side of the register port
// assumes: read data one edge after the request
`timescale 1ns/10ps
module pldc_bus_model (
   // clock
   input  wire logic                  clk,
   // register port
   output pldc_pkg::pldc_bus_req_type req,
   input  wire logic [7:0]            rdata
);
   import pldc_pkg::*;

   initial req = '0;

   task automatic op(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{sel: w | r, wr: w, rd: r, addr: a, wdata: d};
   endtask

   // idle port shows inverted leftovers
   task automatic idle();
      @(posedge clk);
      req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
      idle();
   endtask

   // data taken after the accepting edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      op(1'b0, 1'b1, a, 8'h00);
      idle();
      #1 d = rdata;
   endtask
endmodule

// ---- bench/pldc_cell_checker.sv ----
// pldc_cell_checker: port-level checks of the cell
// assumes: bound into pldc_cell
`timescale 1ns/10ps
`include "pldc_map.svh"
module pldc_cell_checker (
   // clock and reset
   input wire logic                        clk,
   input wire logic                        nrst,
   // register port
   input wire pldc_pkg::pldc_bus_req_type  bus_req,
   input wire logic [7:0]                  bus_rdata,
   // setup and routing
   input wire pldc_pkg::pldc_pla_cfg_type  pla0_cfg,
   input wire pldc_pkg::pldc_pla_cfg_type  pla1_cfg,
   input wire pldc_pkg::pldc_ctrl_type     ctrl,
   input wire pldc_pkg::pldc_cfg_word_type [`PLDC_CFG_WORDS-1:0] cfg_ram,
   input wire logic [`PLDC_PLA_IN-1:0]     pla0_in,
   input wire logic [`PLDC_PLA_IN-1:0]     pla1_in,
   input wire logic [`PLDC_PLA_OUT-1:0]    pla0_out,
   input wire logic [`PLDC_PLA_OUT-1:0]    pla1_out,
   input wire logic [`PLDC_CFG_AW-1:0]     cfg_addr,
   input wire logic [`PLDC_ROUTE_OUTS-1:0] route_out
);
   import pldc_pkg::*;

   logic [2:0] cnt_q;
   logic       push;
   logic       pop;
   logic [3:0] f0;
   logic [3:0] f1;

   // reference sum of products
   function automatic logic [3:0] pla_eval(input pldc_pla_cfg_type c, input logic [11:0] x);
      logic [7:0] t;
      for (int i = 0; i < 8; i++)
         t[i] = |(c.use_t[i] | c.use_c[i]) && !(c.use_t[i] & ~x) && !(c.use_c[i] & x);
      for (int o = 0; o < 4; o++)
         pla_eval[o] = |(c.or_sel[o] & t);
   endfunction

   assign f0 = pla_eval(pla0_cfg, pla0_in);
   assign f1 = pla_eval(pla1_cfg, pla1_in);

   // queue zero fill level, input mode
   assign pop  = cfg_ram[cfg_addr].q0_go && cnt_q != 3'h0;
   assign push = bus_req.sel && bus_req.wr && bus_req.addr == 3'h4 && (cnt_q != 3'h4 || pop);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cnt_q <= 3'h0;
      else
         cnt_q <= cnt_q + {2'h0, push} - {2'h0, pop};
   end

   chk_opnd_readback : assert property (@(posedge clk) disable iff (!nrst)
      (bus_req.sel && bus_req.wr && !bus_req.rd && bus_req.addr[2:1] == 2'h1) ##1
      (bus_req.sel && bus_req.rd && !bus_req.wr && bus_req.addr == $past(bus_req.addr))
      |=> bus_rdata == $past(bus_req.wdata, 2)) else $error("operand readback differs");
   chk_unmapped_zero : assert property (@(posedge clk) disable iff (!nrst)
      bus_req.sel && bus_req.rd && bus_req.addr > 3'h5 |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_hold : assert property (@(posedge clk) disable iff (!nrst)
      !(bus_req.sel && bus_req.rd) |=> $stable(bus_rdata)) else $error("read data moved");
   chk_q0_empty : assert property (@(posedge clk) disable iff (!nrst)
      ctrl.out_sel[0] == 4'hc && !ctrl.q_out[0] |=> route_out[0] == ($past(cnt_q) == 3'h0))
      else $error("queue empty status wrong");
   chk_q0_full : assert property (@(posedge clk) disable iff (!nrst)
      ctrl.out_sel[1] == 4'hd && !ctrl.q_out[0] |=> route_out[1] == ($past(cnt_q) == 3'h4))
      else $error("queue full status wrong");
   chk_pla0_comb : assert property (@(posedge clk) disable iff (!nrst)
      ((pla0_out ^ f0) & ~pla0_cfg.reg_out) == 4'h0) else $error("array zero logic wrong");
   chk_pla0_reg : assert property (@(posedge clk) disable iff (!nrst)
      $past(nrst) |-> ((pla0_out ^ $past(f0)) & pla0_cfg.reg_out) == 4'h0)
      else $error("array zero flop wrong");
   chk_pla1_comb : assert property (@(posedge clk) disable iff (!nrst)
      ((pla1_out ^ f1) & ~pla1_cfg.reg_out) == 4'h0) else $error("array one logic wrong");
endmodule

bind pldc_cell pldc_cell_checker u_pldc_cell_checker (.clk(clk), .nrst(nrst), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .pla0_cfg(pla0_cfg), .pla1_cfg(pla1_cfg), .ctrl(ctrl), .cfg_ram(cfg_ram),
   .pla0_in(pla0_in), .pla1_in(pla1_in), .pla0_out(pla0_out), .pla1_out(pla1_out),
   .cfg_addr(cfg_addr), .route_out(route_out));

// ---- bench/tb_top.sv ----
// tb_top: self-checking bench of the logic cell
// assumes: pldc_pkg compiled first
`timescale 1ns/10ps
`include "pldc_map.svh"
module tb_top;
   import pldc_pkg::*;

   typedef struct packed {
      pldc_op_type    op;
      pldc_shift_type sh;
      logic [7:0]     a;
      logic [7:0]     b;
      logic [7:0]     exp;
   } pldc_row_type;

   logic              clk;
   logic              nrst;
   pldc_bus_req_type  bus_req;
   logic [7:0]        bus_rdata;
   logic [7:0]        rd_val;
   pldc_pla_cfg_type  pla0_cfg;
   pldc_pla_cfg_type  pla1_cfg;
   pldc_ctrl_type     ctrl;
   pldc_cfg_word_type [7:0] cfg_ram;
   logic [11:0]       pla0_in;
   logic [11:0]       pla1_in;
   logic [2:0]        cfg_addr;
   int                err_total;
   int                n_checks;

   // acc0 op opnd0 into acc0, then post-alu stage
   pldc_row_type rows [11] = '{
      '{pldc_op_inc, pldc_sh_none, 8'h7f, 8'h00, 8'h80}, '{pldc_op_dec, pldc_sh_none, 8'h00, 8'h00, 8'hff},
      '{pldc_op_add, pldc_sh_none, 8'hf0, 8'h20, 8'h10}, '{pldc_op_sub, pldc_sh_none, 8'h10, 8'h20, 8'hf0},
      '{pldc_op_and, pldc_sh_none, 8'hcc, 8'haa, 8'h88}, '{pldc_op_or, pldc_sh_none, 8'hcc, 8'haa, 8'hee},
      '{pldc_op_xor, pldc_sh_none, 8'hcc, 8'haa, 8'h66}, '{pldc_op_pass, pldc_sh_none, 8'hcc, 8'haa, 8'hcc},
      '{pldc_op_pass, pldc_sh_left, 8'ha5, 8'h00, 8'h4a}, '{pldc_op_pass, pldc_sh_right, 8'ha5, 8'h00, 8'h52},
      '{pldc_op_pass, pldc_sh_swap, 8'ha5, 8'h00, 8'h5a}};

   pldc_cell u_pldc_cell (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .pla0_cfg(pla0_cfg), .pla1_cfg(pla1_cfg), .ctrl(ctrl), .cfg_ram(cfg_ram), .pla0_in(pla0_in),
      .pla1_in(pla1_in), .pla0_out(), .pla1_out(), .cfg_addr(cfg_addr), .shift_in(1'b0),
      .route_out(), .chain_cin(1'b0), .chain_sin(1'b0), .chain_eq_in(1'b0), .chain_cout(),
      .chain_sout(), .chain_eq_out());

   pldc_bus_model u_pldc_bus_model (.clk(clk), .req(bus_req), .rdata(bus_rdata));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one cycle on word a, then idle word zero
   task automatic run(input logic [2:0] a);
      @(posedge clk);
      cfg_addr <= a;
      @(posedge clk);
      cfg_addr <= 3'h0;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      u_pldc_bus_model.rd(a, rd_val);
      check(rd_val, exp);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang cut far past the normal run
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      stop_test();
   end

   initial begin
      nrst = 1'b0;
      err_total = 0;
      n_checks = 0;
      pla0_in = 12'h000;
      pla1_in = 12'h000;
      cfg_addr = 3'h0;
      ctrl = '0;
      ctrl.msb = 3'h7;
      ctrl.q_out = 2'h2;
      ctrl.out_sel[0] = 4'hc;
      ctrl.out_sel[1] = 4'hd;
      cfg_ram = '0;
      cfg_ram[1].src_b = 2'h2;
      cfg_ram[1].dest = 2'h1;
      cfg_ram[2].q0_go = 1'b1;
      cfg_ram[3].q1_go = 1'b1;
      pla0_cfg = '0;
      pla1_cfg = '0;
      pla0_cfg.reg_out = 4'ha;
      for (int i = 0; i < 8; i++) begin
         pla0_cfg.use_t[i] = 12'h001 << i;
         pla0_cfg.use_c[i] = 12'h010 << i;
         pla1_cfg.use_t[i] = 12'hfff >> i;
      end
      for (int o = 0; o < 4; o++) begin
         pla0_cfg.or_sel[o] = 8'h03 << (2 * o);
         pla1_cfg.or_sel[o] = 8'hff >> o;
      end
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int r = 0; r < 4; r++)
         rd_chk(3'(r), 8'h00);
      // array sweep, judged by the checker
      for (int k = 0; k < 64; k++) begin
         @(posedge clk);
         pla0_in <= 12'(k * 37);
         pla1_in <= ~12'(k * 53);
      end
      foreach (rows[i]) begin
         u_pldc_bus_model.wr(3'h0, rows[i].a);
         u_pldc_bus_model.wr(3'h2, rows[i].b);
         cfg_ram[1].op <= rows[i].op;
         cfg_ram[1].shift <= rows[i].sh;
         run(3'h1);
         rd_chk(3'h0, rows[i].exp);
      end
      u_pldc_bus_model.wr(3'h0, 8'h12);
      u_pldc_bus_model.wr(3'h2, 8'h34);
      cfg_ram[1].op <= pldc_op_add;
      cfg_ram[1].shift <= pldc_sh_none;
      cfg_ram[1].dest <= 2'h3;
      run(3'h1);
      rd_chk(3'h1, 8'h46);
      rd_chk(3'h2, 8'h34);
      // unmapped, then write-read back to back
      u_pldc_bus_model.wr(3'h6, 8'h5a);
      rd_chk(3'h7, 8'h00);
      rd_chk(3'h6, 8'h00);
      u_pldc_bus_model.op(1'b1, 1'b0, 3'h3, 8'hc3);
      u_pldc_bus_model.op(1'b0, 1'b1, 3'h3, 8'h00);
      u_pldc_bus_model.idle();
      #1 check(bus_rdata, 8'hc3);
      for (int k = 1; k < 6; k++)
         u_pldc_bus_model.wr(3'h4, 8'(8'h11 * k));
      for (int k = 1; k < 5; k++) begin
         run(3'h2);
         rd_chk(3'h2, 8'(8'h11 * k));
      end
      u_pldc_bus_model.wr(3'h4, 8'h66);
      run(3'h2);
      rd_chk(3'h2, 8'h66);
      // output queue takes acc1, not bus
      u_pldc_bus_model.wr(3'h1, 8'h77);
      run(3'h3);
      u_pldc_bus_model.wr(3'h1, 8'h88);
      run(3'h3);
      u_pldc_bus_model.wr(3'h5, 8'h99);
      rd_chk(3'h5, 8'h77);
      rd_chk(3'h5, 8'h88);
      rd_chk(3'h5, 8'h00);
      // mid-run reset
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(3'h1, 8'h00);
      stop_test();
   end
endmodule
